/* File: srcl_pkg.sv */
// Constants, types and decode tables of the strap configuration loader
// Assumes a 20 MHz clock and strap readings scaled 1 LSB = 1 kOhm
package srcl_pkg;
   localparam int           CLK_MHZ      = 20;
   localparam int           MEAS_WIN_US  = 1000;
   localparam int           MEAS_WIN_CYC = MEAS_WIN_US * CLK_MHZ;
   localparam logic [7:0]   FLOAT_MIN    = 8'hC8;
   localparam logic [7:0]   GND_MAX      = 8'h03;
   localparam logic [7:0]   VTHR [14]    = '{8'h74, 8'h64, 8'h57, 8'h4B, 8'h41, 8'h38,
      8'h2F, 8'h28, 8'h22, 8'h1C, 8'h17, 8'h13, 8'h0E, 8'h09};
   localparam logic [15:0]  VSP [15]     = '{16'h1388, 16'h0CE4, 16'h09C4, 16'h0708,
      16'h05DC, 16'h0546, 16'h04B0, 16'h044C, 16'h03E8, 16'h0384, 16'h0352, 16'h0320,
      16'h02EE, 16'h02BC, 16'h0258};
   localparam logic [7:0]   PTHR [10]    = '{8'h6D, 8'h57, 8'h47, 8'h38, 8'h2F, 8'h25,
      8'h1C, 8'h15, 8'h0E, 8'h09};
   localparam logic [10:0]  LIM_PM [8]   = '{11'h3E8, 11'h44C, 11'h433, 11'h433,
      11'h41A, 11'h3B6, 11'h3A7, 11'h3A2};
   localparam logic [8:0]   GAIN_US      = 9'h12C;
   localparam logic [1:0]   RNG_LOW      = 2'h0;
   localparam logic [1:0]   RNG_MID      = 2'h1;
   localparam logic [1:0]   RNG_HIGH     = 2'h2;
   localparam logic [2:0]   CAP_80       = 3'h0;
   localparam logic [2:0]   CAP_320      = 3'h1;
   localparam logic [2:0]   RES_10K      = 3'h0;
   localparam logic [2:0]   RES_14K      = 3'h1;
   localparam logic [2:0]   RES_20K      = 3'h2;
   localparam logic [2:0]   RES_60K      = 3'h3;
   localparam logic [9:0]   BAND_LO      = 10'h07D;
   localparam logic [9:0]   BAND_HI      = 10'h0FA;
   localparam logic [15:0]  ROUND_HALF   = 16'h0032;
   localparam logic [15:0]  ROUND_STEP   = 16'h0064;
   localparam logic [7:0]   PHASE_0      = 8'h00;
   localparam logic [7:0]   REG_CTRL     = 8'h00;
   localparam logic [7:0]   REG_NVM_VOUT = 8'h04;
   localparam logic [7:0]   REG_NVM_PWM  = 8'h08;
   localparam logic [7:0]   REG_STATUS   = 8'h0C;
   localparam logic [7:0]   REG_PWM      = 8'h10;
   localparam logic [7:0]   REG_MODE     = 8'h14;
   localparam logic [7:0]   REG_VOUT     = 8'h18;
   localparam logic [7:0]   REG_LIM      = 8'h20;
   localparam int           CTRL_RESTORE = 0;
   localparam int           CTRL_MRESET  = 1;
   localparam int           CTRL_OPON    = 2;
   localparam int           CTRL_ONOFF   = 3;
   localparam int           MODE_CAP_LSB = 6;
   localparam int           MODE_RES_LSB = 3;

   typedef enum logic [1:0] {ONOFF_RUN, ONOFF_OP, ONOFF_BOTH} srcl_onoff_t;
   typedef struct packed {
      logic [15:0] setPoint;
      logic [1:0]  range;
      logic [8:0]  gainUs;
   } srcl_vout_t;
   typedef struct packed {
      srcl_onoff_t onOff;
      srcl_vout_t  vout;
   } srcl_nvmv_t;
   typedef struct packed {
      logic [9:0]  freq10k;
      logic [2:0]  cap;
      logic [2:0]  res;
      logic        clkOut;
      logic [7:0]  phase;
   } srcl_pwm_t;

   localparam srcl_nvmv_t NVM_VOUT_RST = '{ONOFF_RUN, '{16'h01F4, RNG_LOW, GAIN_US}};
   localparam srcl_pwm_t  NVM_PWM_RST  = '{10'h064, CAP_80, RES_10K, 1'b0, PHASE_0};

   function automatic logic [3:0] vIndex(input logic [7:0] r);
      vIndex = 4'h0;
      for (int i = 0; i < 14; i++) if (r < VTHR[i]) vIndex = 4'(i + 1);
   endfunction : vIndex

   function automatic logic [3:0] pIndex(input logic [7:0] r);
      pIndex = 4'h0;
      for (int i = 0; i < 10; i++) if (r < PTHR[i]) pIndex = 4'(i + 1);
   endfunction : pIndex

   function automatic logic [1:0] rangeOf(input logic [3:0] i);
      rangeOf = (i <= 4'h1) ? RNG_HIGH : (i <= 4'h5) ? RNG_MID : RNG_LOW;
   endfunction : rangeOf

   function automatic logic [15:0] pct(input logic [15:0] sp, input logic [10:0] pm);
      pct = 16'((27'(sp) * 27'(pm)) / 27'h00003E8);
   endfunction : pct

   function automatic srcl_pwm_t pwmEntry(input logic [3:0] i);
      unique case (i)
         4'h0:    pwmEntry = '{10'h032, CAP_320, RES_14K, 1'b1, PHASE_0};
         4'h1:    pwmEntry = '{10'h032, CAP_320, RES_14K, 1'b0, PHASE_0};
         4'h2:    pwmEntry = '{10'h04B, CAP_320, RES_14K, 1'b1, PHASE_0};
         4'h3:    pwmEntry = '{10'h04B, CAP_320, RES_14K, 1'b0, PHASE_0};
         4'h4:    pwmEntry = '{10'h064, CAP_320, RES_14K, 1'b1, PHASE_0};
         4'h5:    pwmEntry = '{10'h096, CAP_320, RES_20K, 1'b1, PHASE_0};
         4'h6:    pwmEntry = '{10'h096, CAP_320, RES_20K, 1'b0, PHASE_0};
         4'h7:    pwmEntry = '{10'h0C8, CAP_320, RES_20K, 1'b1, PHASE_0};
         4'h8:    pwmEntry = '{10'h0C8, CAP_320, RES_20K, 1'b0, PHASE_0};
         4'h9:    pwmEntry = '{10'h12C, CAP_80, RES_60K, 1'b0, PHASE_0};
         default: pwmEntry = '{10'h190, CAP_80, RES_60K, 1'b0, PHASE_0};
      endcase
   endfunction : pwmEntry

   function automatic srcl_pwm_t measEntry(input logic [15:0] edgesKhz);
      logic [9:0] f;
      f = 10'(((edgesKhz + ROUND_HALF) / ROUND_STEP) * 16'h000A);
      measEntry = '{f, CAP_320, RES_14K, 1'b0, PHASE_0};
      if (f > BAND_HI) begin
         measEntry.cap = CAP_80;
         measEntry.res = RES_60K;
      end else if (f > BAND_LO) begin
         measEntry.res = RES_20K;
      end
   endfunction : measEntry
endpackage : srcl_pkg

/* File: srcl_loader.sv */
// Strap configuration loader: decodes both straps into initial settings
// Assumes slowly settled strap readings and a plain register port
//
// The implementer's own choices: the register addresses and the address-and-strobe port.
module srcl_loader #(
   parameter int MEAS_WIN = srcl_pkg::MEAS_WIN_CYC
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [7:0]           addr,
   input  wire logic [31:0]          wdata,
   input  wire logic                 wr,
   input  wire logic                 rd,
   output logic [31:0]               rdata,
   input  wire logic [7:0]           voltReading,
   input  wire logic [7:0]           pwmReading,
   input  wire logic                 syncPin,
   input  wire logic                 runPin,
   output logic                      configDone,
   output logic                      regEnable,
   output logic                      syncDriveEnable,
   output srcl_pkg::srcl_vout_t      voutCfg,
   output srcl_pkg::srcl_pwm_t       pwmCfg
);
   // ----------------------------------------
   // Reset release and pin synchronisers
   // ----------------------------------------
   logic [1:0]  rstPipe;
   logic        rstN;
   logic [17:0] pinMeta;
   logic [17:0] pinQ;
   logic        syncPrev;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) rstPipe <= 2'h0;
      else rstPipe <= {rstPipe[0], 1'b1};
   end
   assign rstN = rstPipe[1];

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         pinMeta  <= 18'h00000;
         pinQ     <= 18'h00000;
         syncPrev <= 1'b0;
      end else begin
         pinMeta  <= {syncPin, runPin, voltReading, pwmReading};
         pinQ     <= pinMeta;
         syncPrev <= pinQ[17];
      end
   end

   logic       syncQ;
   logic       runQ;
   logic [7:0] voltQ;
   logic [7:0] pwmQ;
   assign syncQ = pinQ[17];
   assign runQ  = pinQ[16];
   assign voltQ = pinQ[15:8];
   assign pwmQ  = pinQ[7:0];

   // ----------------------------------------
   // Sequencer and clock measurement
   // ----------------------------------------
   typedef enum logic [1:0] {ST_MEASURE, ST_APPLY, ST_DONE} srcl_state_t;
   srcl_state_t state;
   logic [23:0] winCnt;
   logic [15:0] edgesA;
   logic [15:0] edgesB;
   logic        restart;
   logic        winDone;

   assign restart = wr && addr == srcl_pkg::REG_CTRL &&
                    (wdata[srcl_pkg::CTRL_RESTORE] || wdata[srcl_pkg::CTRL_MRESET]);
   assign winDone = winCnt == 24'(MEAS_WIN - 1);

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         state <= ST_MEASURE;
      end else if (restart) begin
         state <= ST_MEASURE;
      end else begin
         unique case (state)
            ST_MEASURE: if (winDone) state <= ST_APPLY;
            ST_APPLY:   state <= ST_DONE;
            ST_DONE:    state <= ST_DONE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         winCnt <= 24'h000000;
         edgesA <= 16'h0000;
         edgesB <= 16'h0000;
      end else if (restart) begin
         winCnt <= 24'h000000;
         edgesA <= 16'h0000;
         edgesB <= 16'h0000;
      end else if (state == ST_MEASURE) begin
         winCnt <= winCnt + 24'h000001;
         if (syncQ && !syncPrev) begin
            if (winCnt < 24'(MEAS_WIN / 2)) edgesA <= edgesA + 16'h0001;
            else edgesB <= edgesB + 16'h0001;
         end
      end
   end

   // ----------------------------------------
   // Strap decode
   // ----------------------------------------
   srcl_pkg::srcl_nvmv_t nvmV;
   srcl_pkg::srcl_pwm_t  nvmP;
   srcl_pkg::srcl_vout_t next_vout;
   srcl_pkg::srcl_pwm_t  next_pwm;
   srcl_pkg::srcl_onoff_t next_onOff;
   logic [3:0] vIdx;
   logic       vGnd;
   logic       vFlt;
   logic       power_ground_pin;
   logic       pFlt;
   logic       clkRun;
   logic       clkChg;

   always_comb begin
      vIdx   = srcl_pkg::vIndex(voltQ);
      vGnd   = voltQ <= srcl_pkg::GND_MAX;
      vFlt   = voltQ >= srcl_pkg::FLOAT_MIN;
      power_ground_pin   = pwmQ <= srcl_pkg::GND_MAX;
      pFlt   = pwmQ >= srcl_pkg::FLOAT_MIN;
      clkRun = edgesA != 16'h0000 && edgesB != 16'h0000;
      clkChg = (edgesA != 16'h0000) != (edgesB != 16'h0000);
      if (vGnd || vFlt) begin
         next_vout  = nvmV.vout;
         next_onOff = nvmV.onOff;
      end else begin
         next_vout.setPoint = srcl_pkg::VSP[vIdx];
         next_vout.range    = srcl_pkg::rangeOf(vIdx);
         next_vout.gainUs   = srcl_pkg::GAIN_US;
         next_onOff         = srcl_pkg::ONOFF_RUN;
      end
      if (clkRun) begin
         next_pwm = srcl_pkg::measEntry(edgesA + edgesB);
      end else if (power_ground_pin || pFlt) begin
         next_pwm = nvmP;
      end else begin
         next_pwm = srcl_pkg::pwmEntry(srcl_pkg::pIndex(pwmQ));
      end
   end

   // ----------------------------------------
   // Derived settings
   // ----------------------------------------
   logic [15:0] limits [8];
   logic        voltGnd;
   logic        voltFlt;
   logic        clkMeasured;
   logic        pinFault;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         voutCfg     <= srcl_pkg::NVM_VOUT_RST.vout;
         pwmCfg      <= srcl_pkg::NVM_PWM_RST;
         voltGnd     <= 1'b0;
         voltFlt     <= 1'b0;
         clkMeasured <= 1'b0;
         pinFault    <= 1'b0;
         for (int i = 0; i < 8; i++) limits[i] <= 16'h0000;
      end else if (state == ST_APPLY) begin
         voutCfg     <= next_vout;
         pwmCfg      <= next_pwm;
         voltGnd     <= vGnd;
         voltFlt     <= vFlt;
         clkMeasured <= clkRun;
         pinFault    <= clkChg || power_ground_pin;
         for (int i = 0; i < 8; i++) begin
            limits[i] <= srcl_pkg::pct(next_vout.setPoint, srcl_pkg::LIM_PM[i]);
         end
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) configDone <= 1'b0;
      else if (restart) configDone <= 1'b0;
      else if (state == ST_APPLY) configDone <= 1'b1;
   end

   // ----------------------------------------
   // Control registers and enable
   // ----------------------------------------
   srcl_pkg::srcl_onoff_t onOff;
   logic                  opOn;
   logic                  enCond;

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         onOff <= srcl_pkg::ONOFF_RUN;
         opOn  <= 1'b0;
      end else if (state == ST_APPLY) begin
         onOff <= next_onOff;
      end else if (wr && addr == srcl_pkg::REG_CTRL) begin
         onOff <= srcl_pkg::srcl_onoff_t'(wdata[srcl_pkg::CTRL_ONOFF +: 2]);
         opOn  <= wdata[srcl_pkg::CTRL_OPON];
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         nvmV <= srcl_pkg::NVM_VOUT_RST;
         nvmP <= srcl_pkg::NVM_PWM_RST;
      end else if (wr) begin
         if (addr == srcl_pkg::REG_NVM_VOUT) nvmV <= srcl_pkg::srcl_nvmv_t'(wdata[28:0]);
         if (addr == srcl_pkg::REG_NVM_PWM) nvmP <= srcl_pkg::srcl_pwm_t'(wdata[24:0]);
      end
   end

   always_comb begin
      unique case (onOff)
         srcl_pkg::ONOFF_RUN:  enCond = runQ;
         srcl_pkg::ONOFF_OP:   enCond = opOn;
         srcl_pkg::ONOFF_BOTH: enCond = runQ && opOn;
         default:              enCond = 1'b0;
      endcase
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         regEnable       <= 1'b0;
         syncDriveEnable <= 1'b0;
      end else begin
         regEnable       <= configDone && !voltGnd && enCond;
         syncDriveEnable <= configDone && pwmCfg.clkOut;
      end
   end

   // ----------------------------------------
   // Register read port
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         rdata <= 32'h00000000;
      end else if (!rd) begin
         rdata <= 32'h00000000;
      end else if (addr[7:5] == srcl_pkg::REG_LIM[7:5]) begin
         rdata <= 32'(limits[addr[4:2]]);
      end else begin
         unique case (addr)
            srcl_pkg::REG_CTRL:     rdata <= 32'({onOff, opOn, 2'h0});
            srcl_pkg::REG_NVM_VOUT: rdata <= 32'(nvmV);
            srcl_pkg::REG_NVM_PWM:  rdata <= 32'(nvmP);
            srcl_pkg::REG_STATUS:   rdata <= 32'({voltFlt, voltGnd, regEnable,
                                                  pinFault, clkMeasured, configDone});
            srcl_pkg::REG_PWM:      rdata <= 32'(pwmCfg);
            srcl_pkg::REG_MODE:     rdata <= (32'(pwmCfg.cap) << srcl_pkg::MODE_CAP_LSB) |
                                             (32'(pwmCfg.res) << srcl_pkg::MODE_RES_LSB);
            srcl_pkg::REG_VOUT:     rdata <= 32'(voutCfg);
            default:                rdata <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   property p_restart;
      @(posedge clk) disable iff (!rstN)
      restart |=> state == ST_MEASURE && !configDone && winCnt == 24'h000000;
   endproperty
   a_restart: assert property (p_restart) else $error("restart did not resample");

   property p_ovLimits;
      @(posedge clk) disable iff (!rstN)
      $rose(configDone) |-> limits[1] == srcl_pkg::pct(limits[0], 11'h44C) &&
         limits[2] == srcl_pkg::pct(limits[0], 11'h433) && limits[3] == limits[2];
   endproperty
   a_ovLimits: assert property (p_ovLimits) else $error("overvoltage limits wrong");

   property p_uvLimits;
      @(posedge clk) disable iff (!rstN)
      configDone |-> limits[4] == srcl_pkg::pct(limits[0], 11'h41A) &&
         limits[7] == srcl_pkg::pct(limits[0], 11'h3A2);
   endproperty
   a_uvLimits: assert property (p_uvLimits) else $error("margin or uv limits wrong");

   property p_gain;
      @(posedge clk) disable iff (!rstN)
      configDone && !voltGnd && !voltFlt |-> voutCfg.gainUs == 9'h12C;
   endproperty
   a_gain: assert property (p_gain) else $error("strap gain not 300 uS");

   property p_gndOff;
      @(posedge clk) disable iff (!rstN)
      configDone && voltGnd |=> !regEnable [*2];
   endproperty
   a_gndOff: assert property (p_gndOff) else $error("grounded strap enabled regulator");

   property p_runOnly;
      @(posedge clk) disable iff (!rstN)
      configDone && !voltGnd && onOff == srcl_pkg::ONOFF_RUN |=> regEnable == $past(runQ);
   endproperty
   a_runOnly: assert property (p_runOnly) else $error("run pin not followed");

   property p_noEarlyEnable;
      @(posedge clk) disable iff (!rstN)
      !configDone |=> !regEnable;
   endproperty
   a_noEarlyEnable: assert property (p_noEarlyEnable) else $error("enable before decode");

   property p_measured;
      @(posedge clk) disable iff (!rstN)
      configDone && clkMeasured |-> !pwmCfg.clkOut && pwmCfg.phase == 8'h00 &&
         pwmCfg.freq10k % 10'h00A == 10'h000;
   endproperty
   a_measured: assert property (p_measured) else $error("measured clock setup wrong");

   property p_applyOnce;
      @(posedge clk) disable iff (!rstN)
      state == ST_APPLY && !restart |=> state == ST_DONE && configDone;
   endproperty
   a_applyOnce: assert property (p_applyOnce) else $error("apply step misbehaved");

   c_restart: cover property (@(posedge clk) disable iff (!rstN) configDone && restart);
   c_measured: cover property (@(posedge clk) disable iff (!rstN) $rose(clkMeasured));
   c_gnd: cover property (@(posedge clk) disable iff (!rstN) configDone && voltGnd);
   c_enable: cover property (@(posedge clk) disable iff (!rstN) $rose(regEnable));
endmodule : srcl_loader

/* File: srcl_strap_model.sv */
// Strap resistors and external sync clock beside the loader
// Assumes readings in kOhm and a clock that is low while idle
module srcl_strap_model (
   input  wire logic [7:0]  vRes,
   input  wire logic [7:0]  pRes,
   input  wire logic        clkOn,
   input  wire logic [31:0] halfPs,
   output logic [7:0]       voltReading,
   output logic [7:0]       pwmReading,
   output logic             syncPin
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // Straps and clock source
   // ---------------------------------------------
   assign voltReading = vRes;
   assign pwmReading  = pRes;
   // Clock held low while clkOn is low; rate near strap choice
   always begin
      if (clkOn) #(halfPs / 1000.0) syncPin = ~syncPin;
      else begin
         syncPin = 1'b0;
         @(clkOn);
      end
   end
endmodule : srcl_strap_model

/* File: srcl_loader_tb_top.sv */
// Testbench of the strap loader: decode tables, limits, clock, enable
// Assumes a shortened window of 4000 cycles (0.2 ms) on the loader
module srcl_loader_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------------------------
   // Signals and tables
   // ---------------------------------------------
   localparam int          WIN = 4000;
   localparam logic [26:0] DV = {16'h01F4, 2'h0, 9'h12C};
   localparam logic [24:0] DP = {10'h064, 3'h0, 3'h0, 1'b0, 8'h00};
   localparam logic [7:0]  VR[15] = '{8'h7C, 8'h6B, 8'h5D, 8'h51, 8'h46, 8'h3C, 8'h33,
      8'h2B, 8'h25, 8'h1F, 8'h1A, 8'h15, 8'h11, 8'h0C, 8'h07};
   localparam logic [15:0] MV[15] = '{16'h1388, 16'h0CE4, 16'h09C4, 16'h0708, 16'h05DC,
      16'h0546, 16'h04B0, 16'h044C, 16'h03E8, 16'h0384, 16'h0352, 16'h0320, 16'h02EE,
      16'h02BC, 16'h0258};
   localparam logic [7:0]  PR[11] = '{8'h7C, 8'h5D, 8'h51, 8'h3C, 8'h34, 8'h2B, 8'h1F,
      8'h1A, 8'h11, 8'h0C, 8'h07};
   localparam logic [10:0] PT[11] = '{11'h065, 11'h064, 11'h097, 11'h096, 11'h0C9,
      11'h12D, 11'h12C, 11'h191, 11'h190, 11'h258, 11'h320};
   localparam logic [10:0] PM[8] = '{11'h3E8, 11'h44C, 11'h433, 11'h433, 11'h41A,
      11'h3B6, 11'h3A7, 11'h3A2};
   logic                 clk = 1'b0;
   logic                 resetn = 1'b0;
   logic [7:0]           addr = 8'h00;
   logic [31:0]          wdata = 32'h0;
   logic                 wr = 1'b0;
   logic                 rd = 1'b0;
   logic [31:0]          rdata;
   logic [7:0]           vRes = 8'hC8;
   logic [7:0]           pRes = 8'hFF;
   logic                 clkOn = 1'b0;
   logic [31:0]          halfPs = 32'h0;
   logic                 runPin = 1'b0;
   logic [7:0]           voltReading;
   logic [7:0]           pwmReading;
   logic                 syncPin;
   logic                 configDone;
   logic                 regEnable;
   logic                 syncDriveEnable;
   srcl_pkg::srcl_vout_t voutCfg;
   srcl_pkg::srcl_pwm_t  pwmCfg;
   int                   n_fail = 0;
   int                   total_checks = 0;

   srcl_loader #(.MEAS_WIN(WIN)) uut (.clk(clk), .resetn(resetn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .voltReading(voltReading),
      .pwmReading(pwmReading), .syncPin(syncPin), .runPin(runPin),
      .configDone(configDone), .regEnable(regEnable),
      .syncDriveEnable(syncDriveEnable), .voutCfg(voutCfg), .pwmCfg(pwmCfg));
   srcl_strap_model strap (.vRes(vRes), .pRes(pRes), .clkOn(clkOn), .halfPs(halfPs),
      .voltReading(voltReading), .pwmReading(pwmReading), .syncPin(syncPin));

   always #25 clk = ~clk;
   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic ck(input string w, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", w, e, g);
      end
   endtask : ck
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      d = rdata;
   endtask : rreg
   task automatic waitDone;
      int n;
      n = 0;
      while (configDone !== 1'b1 && n < WIN + 20) begin
         @(posedge clk);
         #1;
         n++;
         // Enable may trail the restart edge by one cycle, then stays low
         if (configDone !== 1'b1 && regEnable !== 1'b0) begin
            ck("early", 32'h0, 32'(regEnable));
         end
      end
      ck("done", 32'h1, 32'(configDone));
      repeat (6) @(posedge clk);
   endtask : waitDone
   task automatic go(input logic [31:0] cmd);
      wreg(8'h00, cmd);
      #1;
      ck("clear", 32'h0, 32'(configDone));
      waitDone();
   endtask : go
   function automatic logic [24:0] expPwm(input logic [9:0] f, input logic o);
      expPwm = {f, 3'h1, 3'h1, o, 8'h00};
      if (f > 10'h0FA) expPwm[14:9] = {3'h0, 3'h3};
      else if (f > 10'h07D) expPwm[11:9] = 3'h2;
   endfunction : expPwm
   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset;
      repeat (3) @(posedge clk);
      ck("rstV", 32'(DV), 32'(voutCfg));
      ck("rstP", 32'(DP), 32'(pwmCfg));
      repeat (2) @(posedge clk);
      resetn <= 1'b1;
      waitDone();
      ck("puV", 32'(DV), 32'(voutCfg));
      ck("puP", 32'(DP), 32'(pwmCfg));
   endtask : t_reset
   task automatic t_straps;
      int j;
      logic [1:0] rg;
      logic [24:0] ep;
      logic [31:0] d;
      for (int i = 0; i < 15; i++) begin
         j = i % 11;
         vRes   <= VR[i];
         pRes   <= PR[j];
         runPin <= 1'b1;
         go(i[0] ? 32'h2 : 32'h1);
         rg = (i < 2) ? 2'h2 : (i < 6) ? 2'h1 : 2'h0;
         ck("vout", 32'({MV[i], rg, 9'h12C}), 32'(voutCfg));
         ep = expPwm(PT[j][10:1], PT[j][0]);
         ck("pwm", 32'(ep), 32'(pwmCfg));
         ck("drive", 32'(PT[j][0]), 32'(syncDriveEnable));
         ck("enable", 32'h1, 32'(regEnable));
         rreg(8'h14, d);
         ck("mode", 32'({ep[14:9], 3'h0}), d);
         for (int k = 0; k < 8; k++) begin
            rreg(8'(8'h20 + 4 * k), d);
            ck("limit", 32'(MV[i]) * 32'(PM[k]) / 32'h3E8, d);
         end
      end
      runPin <= 1'b0;
      repeat (6) @(posedge clk);
      ck("runLow", 32'h0, 32'(regEnable));
   endtask : t_straps
   task automatic t_nvm;
      logic [31:0] d;
      wreg(8'h04, {5'h0, 16'h04D2, 2'h1, 9'h0C8});
      wreg(8'h08, {7'h0, 10'h0AA, 3'h1, 3'h2, 1'b1, 8'h00});
      vRes   <= 8'hFF;
      pRes   <= 8'hC8;
      runPin <= 1'b1;
      go(32'h1);
      ck("nvmV", 32'({16'h04D2, 2'h1, 9'h0C8}), 32'(voutCfg));
      ck("nvmP", {7'h0, 10'h0AA, 3'h1, 3'h2, 1'b1, 8'h00}, 32'(pwmCfg));
      ck("nvmDrv", 32'h1, 32'(syncDriveEnable));
      ck("nvmEn", 32'h1, 32'(regEnable));
      rreg(8'h0C, d);
      ck("fltFlag", 32'h1, 32'(d[5]));
      ck("stEn", 32'h1, 32'(d[3]));
      rreg(8'h04, d);
      ck("nvmRd", 32'({2'h0, 16'h04D2, 2'h1, 9'h0C8}), d);
      vRes <= 8'h03;
      go(32'h2);
      ck("gndEn", 32'h0, 32'(regEnable));
      ck("gndV", 32'({16'h04D2, 2'h1, 9'h0C8}), 32'(voutCfg));
      rreg(8'h0C, d);
      ck("gndFlag", 32'h1, 32'(d[4]));
   endtask : t_nvm
   task automatic t_clock(input logic [31:0] hp, input logic [9:0] f);
      logic [31:0] d;
      halfPs <= hp;
      clkOn  <= 1'b1;
      pRes   <= 8'hFF;
      repeat (20) @(posedge clk);
      go(32'h1);
      ck("measP", 32'(expPwm(f, 1'b0)), 32'(pwmCfg));
      ck("measDrv", 32'h0, 32'(syncDriveEnable));
      rreg(8'h0C, d);
      ck("measFlag", 32'h1, 32'(d[1]));
      rreg(8'h10, d);
      ck("pwmReg", 32'(expPwm(f, 1'b0)), d);
      clkOn <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : t_clock
   task automatic t_fault;
      logic [31:0] d;
      pRes <= 8'h5D;
      repeat (20) @(posedge clk);
      fork
         go(32'h1);
         begin
            repeat (WIN / 2 + 200) @(posedge clk);
            clkOn <= 1'b1;
         end
      join
      rreg(8'h0C, d);
      ck("pinFault", 32'h1, 32'(d[2]));
      clkOn <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : t_fault
   task automatic t_onoff;
      logic [31:0] d;
      logic e;
      vRes <= 8'h7C;
      go(32'h1);
      for (int m = 0; m < 3; m++) begin
         for (int b = 0; b < 4; b++) begin
            runPin <= b[0];
            wreg(8'h00, 32'({m[1:0], b[1], 2'h0}));
            repeat (6) @(posedge clk);
            e = (m == 0) ? b[0] : (m == 1) ? b[1] : b[0] & b[1];
            ck("onOff", 32'(e), 32'(regEnable));
            rreg(8'h00, d);
            ck("ctrl", 32'({m[1:0], b[1], 2'h0}), d);
         end
      end
      #1;
      ck("idle", 32'h0, rdata);
      rreg(8'h40, d);
      ck("unmapped", 32'h0, d);
   endtask : t_onoff
   task automatic give_verdict;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : give_verdict
   // ---------------------------------------------
   // Sequence and watchdog
   // ---------------------------------------------
   initial begin
      t_reset();
      t_straps();
      t_nvm();
      t_clock(32'h00018E99, 10'h064);
      t_clock(32'h00010B8D, 10'h096);
      t_fault();
      t_onoff();
      give_verdict();
   end
   initial begin
      repeat (98000) @(posedge clk);
      n_fail++;
      give_verdict();
   end
endmodule : srcl_loader_tb_top
